// ---- pkg/hse_defs.svh ----
`ifndef HSE_DEFS_SVH
`define HSE_DEFS_SVH

// register pointers seen over the serial bus
`define HSE_REG_CFG 8'h06
`define HSE_REG_LATCH_PG 8'h07
`define HSE_REG_LATCH_OC 8'h08
`define HSE_REG_LIVE 8'h09
`define HSE_REG_CTRL 8'h0A

// latched power-good / timeout register fields
`define HSE_PG_HI_BIT 4
`define HSE_FLT_HI_BIT 5
`define HSE_PG_LO_BIT 6
`define HSE_FLT_LO_BIT 7

// latched overcurrent register fields
`define HSE_OC_HI_BIT 4
`define HSE_FTR_HI_BIT 5
`define HSE_OC_LO_BIT 6
`define HSE_FTR_LO_BIT 7

// live status register fields
`define HSE_BS_HI_BIT 3
`define HSE_PS_HI_BIT 4
`define HSE_BS_LO_BIT 5
`define HSE_GS_LO_BIT 7

// configuration and control fields
`define HSE_CFG_XDIS_BIT 7
`define HSE_CTRL_HI_EN_BIT 0
`define HSE_CTRL_LO_EN_BIT 1
`define HSE_CTRL_HI_BLEED_BIT 2
`define HSE_CTRL_LO_BLEED_BIT 3

// reset values
`define HSE_CFG_RST 8'h00
`define HSE_CTRL_RST 8'h00
`define HSE_LATCH_RST 8'h00

// serial bus; the device address value is arbitrary
`define HSE_BITS_PER_BYTE 4'h8
`define HSE_LAST_RD_BIT 4'h7
`define HSE_DEV_ADDR_RST 7'h2A

`endif

// ---- pkg/hse_pkg.sv ----
/*
 Types shared by the hot-swap status and enable logic.
 Assumes hse_defs.svh is on the include path.
*/
package hse_pkg;

   typedef enum logic [6:0] {
      HSE_IDLE  = 7'h01,
      HSE_ADDR  = 7'h02,
      HSE_ACK_A = 7'h04,
      HSE_WR    = 7'h08,
      HSE_ACK_W = 7'h10,
      HSE_RD    = 7'h20,
      HSE_RD_AK = 7'h40
   } hse_state_type;

   typedef struct packed {
      hse_state_type st;
      logic scl_p;
      logic sda_p;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic first;
      logic [7:0] ptr;
      logic sda_oe;
      logic [7:0] cfg;
      logic [7:0] ctrl;
      logic [7:0] lat_pg;
      logic [7:0] lat_oc;
      logic hi_on;
      logic lo_on;
      logic xconn;
   } hse_regs_type;

endpackage : hse_pkg

// ---- verification/hse_host.sv ----
/*
 Serial-bus host model: drives the bus clock and an open-drain data line,
 with register write and pointer-then-read tasks.
 Assumes it forms the wired data level from both pull-downs.
*/
`timescale 1ns/1ps
`include "hse_defs.svh"

module hse_host #(
   parameter logic [6:0] DEV_ADDR = `HSE_DEV_ADDR_RST
) (
   input wire logic i_clk_sys,
   input wire logic i_sda_oe,
   input wire logic i_sda_o,
   output logic o_scl,
   output logic o_sda,
   output int o_nacks
);
   logic pull_r = 1'b0;
   logic scl_r = 1'b1;
   int nacks = 0;
   // pull-up: a released line reads high; an enabled device drives its own level
   assign o_sda = ~pull_r & (~i_sda_oe | i_sda_o);
   assign o_scl = scl_r;
   assign o_nacks = nacks;

   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : wait_clk

   // phases of 4 cycles, twice the minimum, to allow for input sampling lag
   task automatic bit_io(input logic b, output logic r);
      pull_r <= ~b;
      wait_clk(4);
      scl_r <= 1'b1;
      wait_clk(2);
      #1 r = o_sda;
      wait_clk(2);
      scl_r <= 1'b0;
      wait_clk(1);
   endtask : bit_io

   task automatic put_byte(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      if (r !== 1'b0) nacks++;
   endtask : put_byte

   task automatic get_byte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      // not-acknowledge ends the read
      bit_io(1'b1, r);
   endtask : get_byte

   task automatic start_cond();
      pull_r <= 1'b0;
      wait_clk(2);
      scl_r <= 1'b1;
      wait_clk(4);
      pull_r <= 1'b1;
      wait_clk(4);
      scl_r <= 1'b0;
      wait_clk(2);
   endtask : start_cond

   task automatic stop_cond();
      pull_r <= 1'b1;
      wait_clk(2);
      scl_r <= 1'b1;
      wait_clk(4);
      pull_r <= 1'b0;
      wait_clk(4);
   endtask : stop_cond

   task automatic wr_reg(input logic [7:0] p, input logic [7:0] v);
      start_cond();
      put_byte({DEV_ADDR, 1'b0});
      put_byte(p);
      put_byte(v);
      stop_cond();
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] p, output logic [7:0] v);
      start_cond();
      put_byte({DEV_ADDR, 1'b0});
      put_byte(p);
      start_cond();
      put_byte({DEV_ADDR, 1'b1});
      get_byte(v);
      stop_cond();
   endtask : rd_reg
endmodule : hse_host

// ---- verification/tb_hse_top.sv ----
/*
 Self-checking bench for the hot-swap status and enable logic.
 Assumes the host model in hse_host.sv and the register map in hse_defs.svh.
*/
`timescale 1ns/1ps
`include "hse_defs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_hse_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic hi_pin = 1'b1, lo_pin = 1'b1, lo_float = 1'b0;
   logic [7:0] ev8 = 8'h00, ev7 = 8'h00;
   logic bg = 1'b0, pon = 1'b0, gok = 1'b0, xc = 1'b0;
   logic [1:0] bleed = 2'b00;
   logic [7:0] d, m;
   logic [31:0] seed = 32'd85186;
   wire scl, sda, sda_o, sda_oe, hi_on, lo_on;
   tri1 lo_pin_w;
   int nacks;
   int fail_count = 0;
   int checks = 0;

   // floating pin models the pad pull-up
   assign lo_pin_w = lo_float ? 1'bz : lo_pin;
   always #2 clk = ~clk;

   hse_top i_hse_top (.i_clk_sys(clk), .i_resetn(resetn), .i_ce(ce), .i_scl(scl),
      .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_hi_rail_enable_pin(hi_pin),
      .i_lo_rail_enable_pin(lo_pin_w), .i_hi_pass_below_timer(ev8[4]), .i_hi_fast_trip(ev8[5]),
      .i_lo_gate_below_timer(ev8[6]), .i_lo_fast_trip(ev8[7]), .i_hi_rail_output_pg_low(ev7[4]),
      .i_lo_rail_output_pg_low(ev7[6]), .i_hi_timer_expired(ev7[5]), .i_lo_timer_expired(ev7[7]),
      .i_hi_rail_block_gate_drive(bg), .i_lo_pass_on_cmd(pon), .i_lo_gate_drive_ok(gok),
      .i_hi_rail_output_below_bleed(bleed[0]), .i_lo_rail_output_below_bleed(bleed[1]),
      .i_lo_rail_output_below_xconn(xc), .o_hi_rail_on(hi_on), .o_lo_rail_on(lo_on));

   hse_host i_hse_host (.i_clk_sys(clk), .i_sda_oe(sda_oe), .i_sda_o(sda_o), .o_scl(scl), .o_sda(sda),
      .o_nacks(nacks));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [7:0] live_exp(input logic b, input logic p, input logic o,
      input logic g);
      return {~g, 1'b0, ~o, p, b, 3'b000};
   endfunction : live_exp

   task automatic results();
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   task automatic chk_rd(input logic [7:0] p, input logic [7:0] e);
      i_hse_host.rd_reg(p, d);
      `CHK(d, e)
   endtask : chk_rd

   task automatic wr(input logic [7:0] p, input logic [7:0] v);
      i_hse_host.wr_reg(p, v);
   endtask : wr

   // rail outputs follow their cause one cycle later; allow margin
   task automatic rails(input logic [1:0] e);
      repeat (3) @(posedge clk);
      `CHK({hi_on, lo_on}, e)
   endtask : rails

   initial begin
      repeat (80000) @(posedge clk);
      fail_count++;
      results();
   end

   initial begin
      repeat (4) @(posedge clk);
      #1 `CHK({hi_on, lo_on}, 2'b00)
      @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk_rd(`HSE_REG_CFG, `HSE_CFG_RST);
      chk_rd(`HSE_REG_CTRL, `HSE_CTRL_RST);
      chk_rd(`HSE_REG_LATCH_PG, `HSE_LATCH_RST);
      chk_rd(`HSE_REG_LATCH_OC, `HSE_LATCH_RST);
      for (int i = 0; i < 6; i++) begin
         m = (i == 0) ? 8'h00 : (i == 1) ? 8'h0F : 8'(rnd());
         {bg, ev8[4], pon, gok} <= m[3:0];
         @(posedge clk);
         chk_rd(`HSE_REG_LIVE, live_exp(m[3], m[2], m[1], m[0]));
      end
      wr(`HSE_REG_LIVE, 8'hFF);
      chk_rd(`HSE_REG_LIVE, live_exp(m[3], m[2], m[1], m[0]));
      ev8 <= 8'h00;
      // lo pin floats while driven low at i == 7; the pull-up must win
      for (int i = 0; i < 16; i++) begin
         hi_pin <= i[2];
         lo_pin <= i[3];
         lo_float <= (i == 7);
         wr(`HSE_REG_CTRL, {6'h00, i[1:0]});
         rails({i[0] & i[2], i[1] & (i[3] | (i == 7))});
      end
      chk_rd(`HSE_REG_LATCH_OC, 8'hF0);
      chk_rd(`HSE_REG_LATCH_OC, 8'h00);
      chk_rd(`HSE_REG_LATCH_PG, 8'h50);
      chk_rd(`HSE_REG_LATCH_PG, 8'h00);
      for (int j = 0; j < 10; j++) begin
         m = (j < 4) ? (8'h10 << j) : (8'(rnd()) & 8'hF0);
         ev8 <= m;
         ev7 <= m;
         @(posedge clk);
         ev8 <= 8'h00;
         ev7 <= 8'h00;
         repeat (20) @(posedge clk);
         chk_rd(`HSE_REG_LATCH_OC, m);
         chk_rd(`HSE_REG_LATCH_OC, 8'h00);
         chk_rd(`HSE_REG_LATCH_PG, m);
         chk_rd(`HSE_REG_LATCH_PG, 8'h00);
      end
      wr(`HSE_REG_LATCH_OC, 8'hFF);
      chk_rd(`HSE_REG_LATCH_OC, 8'h00);
      wr(`HSE_REG_LATCH_PG, 8'hFF);
      chk_rd(`HSE_REG_LATCH_PG, 8'h00);
      // an event still present at the clearing read keeps its flag
      ev8 <= 8'h80;
      chk_rd(`HSE_REG_LATCH_OC, 8'h80);
      chk_rd(`HSE_REG_LATCH_OC, 8'h80);
      ev8 <= 8'h00;
      chk_rd(`HSE_REG_LATCH_OC, 8'h80);
      chk_rd(`HSE_REG_LATCH_OC, 8'h00);
      lo_pin <= 1'b1;
      lo_float <= 1'b0;
      wr(`HSE_REG_CTRL, 8'h00);
      wr(`HSE_REG_CTRL, 8'h0F);
      rails(2'b00);
      bleed <= 2'b11;
      rails(2'b11);
      xc <= 1'b1;
      rails(2'b01);
      xc <= 1'b0;
      rails(2'b01);
      wr(`HSE_REG_CTRL, 8'h0E);
      wr(`HSE_REG_CTRL, 8'h0F);
      rails(2'b11);
      wr(`HSE_REG_CFG, 8'h80);
      xc <= 1'b1;
      rails(2'b11);
      chk_rd(`HSE_REG_CFG, 8'h80);
      // clock enable low freezes the rails although the pin drops
      ce <= 1'b0;
      hi_pin <= 1'b0;
      rails(2'b11);
      ce <= 1'b1;
      rails(2'b01);
      // reset in mid-run with a rail on
      resetn <= 1'b0;
      rails(2'b00);
      resetn <= 1'b1;
      @(posedge clk);
      chk_rd(`HSE_REG_CFG, `HSE_CFG_RST);
      chk_rd(`HSE_REG_LATCH_OC, `HSE_LATCH_RST);
      `CHK(nacks, 0)
      results();
   end
endmodule : tb_hse_top

// ---- verilog/hse_top.sv ----
/*
 Status and enable logic of a two-rail hot-swap controller with a
 serial (two-wire) register port: latched and live status registers,
 channel enable gating, bleed-down gating and cross-connect shutoff.
 Assumes comparator inputs and the bus pins are synchronous to
 i_clk_sys, and that i_resetn is the power-on reset.
*/
// Functional notes
// (R01) hi rail current limit sets latched overcurrent bit 4.
// (R02) hi rail fast trip sets latched bit 5.
// (R03) lo rail gate drop sets latched overcurrent bit 6.
// (R04) lo rail fast trip sets latched bit 7.
// (R05) latched flags hold until their register is read.
// (R06) turn-on sets the overcurrent flags; host reads twice after turn-on.
// (R07) live bit 3 high while hi rail block gate commanded high.
// (R08) live bit 4 low while hi rail pass gate above timer start.
// (R09) live bit 5 low while lo rail pass FET commanded on.
// (R10) live bit 7 low while lo rail gate drive exceeds 1.75 V.
// (R11) live register is read-only, unlatched, no read side effect.
// (R12) both rails held off while in power-up reset.
// (R13) power-on reset loads every register with its default.
// (R14) a rail runs only with its pin and enable bit both active.
// (R15) lo rail enable pin active high, floating reads asserted.
// (R16) bleed bit blocks turn-on until output below about 100 mV.
// (R17) lo output below 2.85 V shuts hi rail unless disabled.
// (R18) power-good and timeout flags sit in register 7 bits 4..7.
// (R19) timeout flags latch on timer expiry until register 7 read.
// (R20) after cross-connect trip hi rail waits for enable bit cycle.
// (R21) clear-on-read acts after the byte completes; set beats clear.
// (R22) spare bits read zero; writes to status registers ignored. The config and control registers keep and return all 8 written bits.
`timescale 1ns/1ps
`include "hse_defs.svh"

module hse_top
   import hse_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = `HSE_DEV_ADDR_RST
) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   input wire logic i_hi_rail_enable_pin,
   input wire logic i_lo_rail_enable_pin,
   input wire logic i_hi_pass_below_timer,
   input wire logic i_hi_fast_trip,
   input wire logic i_lo_gate_below_timer,
   input wire logic i_lo_fast_trip,
   input wire logic i_hi_rail_output_pg_low,
   input wire logic i_lo_rail_output_pg_low,
   input wire logic i_hi_timer_expired,
   input wire logic i_lo_timer_expired,
   input wire logic i_hi_rail_block_gate_drive,
   input wire logic i_lo_pass_on_cmd,
   input wire logic i_lo_gate_drive_ok,
   input wire logic i_hi_rail_output_below_bleed,
   input wire logic i_lo_rail_output_below_bleed,
   input wire logic i_lo_rail_output_below_xconn,
   output logic o_hi_rail_on,
   output logic o_lo_rail_on
);

   hse_regs_type r_r;
   hse_regs_type r_nxt;

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic rd_done;
   logic clr_pg;
   logic clr_oc;
   logic [7:0] set_pg;
   logic [7:0] set_oc;
   logic hi_up;
   logic lo_up;
   logic xconn_trip;
   logic hi_on_nxt;
   logic lo_on_nxt;
   logic [7:0] rd_v;

   // read mux, also used when reloading the next read byte
   function automatic logic [7:0] rd_byte(input hse_regs_type r, input logic [7:0] ptr);
      logic [7:0] v;
      v = 8'h00;
      case (ptr)
         `HSE_REG_CFG: v = r.cfg;
         `HSE_REG_CTRL: v = r.ctrl;
         `HSE_REG_LATCH_PG: v = r.lat_pg & 8'hF0; // see (R22)
         `HSE_REG_LATCH_OC: v = r.lat_oc & 8'hF0; // see (R22)
         `HSE_REG_LIVE: begin
            // live, no storage, so reading has no side effect; see (R11)
            v[`HSE_BS_HI_BIT] = i_hi_rail_block_gate_drive; // see (R07)
            v[`HSE_PS_HI_BIT] = i_hi_pass_below_timer; // see (R08)
            v[`HSE_BS_LO_BIT] = ~i_lo_pass_on_cmd; // see (R09)
            v[`HSE_GS_LO_BIT] = ~i_lo_gate_drive_ok; // see (R10)
         end
         default: v = 8'h00;
      endcase
      return v;
   endfunction : rd_byte

   assign scl_rise = i_scl & ~r_r.scl_p;
   assign scl_fall = ~i_scl & r_r.scl_p;
   assign bus_start = i_scl & r_r.scl_p & r_r.sda_p & ~i_sda;
   assign bus_stop = i_scl & r_r.scl_p & ~r_r.sda_p & i_sda;

   // clear only once the master has clocked the acknowledge bit; see (R21)
   assign rd_done = i_ce & (r_r.st == HSE_RD_AK) & scl_rise;
   assign clr_pg = rd_done & (r_r.ptr == `HSE_REG_LATCH_PG);
   assign clr_oc = rd_done & (r_r.ptr == `HSE_REG_LATCH_OC);

   // channel enables; pin, bit, bleed gate and cross-connect
   assign xconn_trip = r_r.hi_on & ~r_r.cfg[`HSE_CFG_XDIS_BIT] & i_lo_rail_output_below_xconn; // see (R17)
   assign hi_on_nxt = i_hi_rail_enable_pin & r_r.ctrl[`HSE_CTRL_HI_EN_BIT] // see (R14)
      & (r_r.hi_on | ~r_r.ctrl[`HSE_CTRL_HI_BLEED_BIT] | i_hi_rail_output_below_bleed) // see (R16)
      & ~xconn_trip & ~r_r.xconn; // see (R20)
   // pull-up on the pin lives in the pad; a floating pin arrives here as 1
   assign lo_on_nxt = i_lo_rail_enable_pin & r_r.ctrl[`HSE_CTRL_LO_EN_BIT] // see (R14) (R15)
      & (r_r.lo_on | ~r_r.ctrl[`HSE_CTRL_LO_BLEED_BIT] | i_lo_rail_output_below_bleed); // see (R16)
   assign hi_up = hi_on_nxt & ~r_r.hi_on;
   assign lo_up = lo_on_nxt & ~r_r.lo_on;

   always_comb begin
      set_oc = 8'h00;
      set_oc[`HSE_OC_HI_BIT] = i_hi_pass_below_timer | hi_up; // see (R01) (R06)
      set_oc[`HSE_FTR_HI_BIT] = i_hi_fast_trip | hi_up; // see (R02) (R06)
      set_oc[`HSE_OC_LO_BIT] = i_lo_gate_below_timer | lo_up; // see (R03) (R06)
      set_oc[`HSE_FTR_LO_BIT] = i_lo_fast_trip | lo_up; // see (R04) (R06)
      set_pg = 8'h00;
      set_pg[`HSE_PG_HI_BIT] = i_hi_rail_output_pg_low | hi_up; // see (R18)
      set_pg[`HSE_FLT_HI_BIT] = i_hi_timer_expired; // see (R19)
      set_pg[`HSE_PG_LO_BIT] = i_lo_rail_output_pg_low | lo_up; // see (R18)
      set_pg[`HSE_FLT_LO_BIT] = i_lo_timer_expired; // see (R19)
   end

   always_comb begin
      r_nxt = r_r;
      rd_v = rd_byte(r_r, r_r.ptr);
      r_nxt.scl_p = i_scl;
      r_nxt.sda_p = i_sda;
      // set wins over the read clear; see (R05) (R21)
      r_nxt.lat_oc = (r_r.lat_oc & {8{~clr_oc}}) | set_oc;
      r_nxt.lat_pg = (r_r.lat_pg & {8{~clr_pg}}) | set_pg;
      r_nxt.hi_on = hi_on_nxt;
      r_nxt.lo_on = lo_on_nxt;
      // trip stays latched until software drops the enable bit, trip wins; see (R20)
      if (xconn_trip) begin
         r_nxt.xconn = 1'b1;
      end else if (!r_r.ctrl[`HSE_CTRL_HI_EN_BIT]) begin
         r_nxt.xconn = 1'b0;
      end
      if (bus_start) begin
         r_nxt.st = HSE_ADDR;
         r_nxt.cnt = 4'h0;
         r_nxt.sda_oe = 1'b0;
      end else if (bus_stop) begin
         r_nxt.st = HSE_IDLE;
         r_nxt.sda_oe = 1'b0;
      end else begin
         case (r_r.st)
            HSE_IDLE: begin
               r_nxt.sda_oe = 1'b0;
            end
            HSE_ADDR, HSE_WR: begin
               if (scl_rise) begin
                  r_nxt.sh = {r_r.sh[6:0], i_sda};
                  r_nxt.cnt = r_r.cnt + 4'h1;
               end else if (scl_fall && r_r.cnt == `HSE_BITS_PER_BYTE) begin
                  if (r_r.st == HSE_ADDR) begin
                     if (r_r.sh[7:1] == DEV_ADDR) begin
                        r_nxt.rw = r_r.sh[0];
                        r_nxt.sda_oe = 1'b1;
                        r_nxt.st = HSE_ACK_A;
                     end else begin
                        r_nxt.st = HSE_IDLE;
                     end
                  end else begin
                     r_nxt.sda_oe = 1'b1;
                     r_nxt.st = HSE_ACK_W;
                     if (r_r.first) begin
                        r_nxt.ptr = r_r.sh;
                     end else if (r_r.ptr == `HSE_REG_CFG) begin
                        r_nxt.cfg = r_r.sh;
                     end else if (r_r.ptr == `HSE_REG_CTRL) begin
                        r_nxt.ctrl = r_r.sh;
                     end
                     // status registers ignore writes; see (R22)
                  end
               end
            end
            HSE_ACK_A: begin
               if (scl_fall) begin
                  r_nxt.cnt = 4'h0;
                  if (r_r.rw) begin
                     r_nxt.sh = rd_v;
                     r_nxt.sda_oe = ~rd_v[7];
                     r_nxt.st = HSE_RD;
                  end else begin
                     r_nxt.sda_oe = 1'b0;
                     r_nxt.first = 1'b1;
                     r_nxt.st = HSE_WR;
                  end
               end
            end
            HSE_ACK_W: begin
               if (scl_fall) begin
                  r_nxt.sda_oe = 1'b0;
                  r_nxt.cnt = 4'h0;
                  r_nxt.first = 1'b0;
                  r_nxt.st = HSE_WR;
               end
            end
            HSE_RD: begin
               if (scl_fall) begin
                  if (r_r.cnt == `HSE_LAST_RD_BIT) begin
                     r_nxt.sda_oe = 1'b0;
                     r_nxt.st = HSE_RD_AK;
                  end else begin
                     r_nxt.cnt = r_r.cnt + 4'h1;
                     r_nxt.sh = {r_r.sh[6:0], 1'b0};
                     r_nxt.sda_oe = ~r_r.sh[6];
                  end
               end
            end
            HSE_RD_AK: begin
               // pointer does not advance; repeat reads return the same register
               if (scl_rise) begin
                  r_nxt.rw = ~i_sda;
               end else if (scl_fall) begin
                  if (r_r.rw) begin
                     r_nxt.cnt = 4'h0;
                     r_nxt.sh = rd_v;
                     r_nxt.sda_oe = ~rd_v[7];
                     r_nxt.st = HSE_RD;
                  end else begin
                     r_nxt.st = HSE_IDLE;
                  end
               end
            end
            default: begin
               r_nxt.st = HSE_IDLE;
               r_nxt.sda_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         // power-on defaults, rails off while held; see (R12) (R13)
         r_r.st <= HSE_IDLE;
         r_r.scl_p <= 1'b1;
         r_r.sda_p <= 1'b1;
         r_r.cnt <= 4'h0;
         r_r.sh <= 8'h00;
         r_r.rw <= 1'b0;
         r_r.first <= 1'b0;
         r_r.ptr <= 8'h00;
         r_r.sda_oe <= 1'b0;
         r_r.cfg <= `HSE_CFG_RST;
         r_r.ctrl <= `HSE_CTRL_RST;
         r_r.lat_pg <= `HSE_LATCH_RST;
         r_r.lat_oc <= `HSE_LATCH_RST;
         r_r.hi_on <= 1'b0;
         r_r.lo_on <= 1'b0;
         r_r.xconn <= 1'b0;
      end else if (i_ce) begin
         r_r <= r_nxt;
      end
   end

   assign o_sda_o = 1'b0;
   assign o_sda_oe = r_r.sda_oe;
   assign o_hi_rail_on = r_r.hi_on;
   assign o_lo_rail_on = r_r.lo_on;

   sequence s_xtrip;
      i_ce && o_hi_rail_on && !r_r.cfg[`HSE_CFG_XDIS_BIT] && i_lo_rail_output_below_xconn;
   endsequence

   sequence s_hi_turn_on;
      i_ce && !o_hi_rail_on ##1 o_hi_rail_on;
   endsequence

   property p_hi_oc_set;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && i_hi_pass_below_timer |=> r_r.lat_oc[`HSE_OC_HI_BIT];
   endproperty
   a_hi_oc_set: assert property (p_hi_oc_set) else $error("hi overcurrent flag not set"); // see (R01)

   property p_hi_ftr_set;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && i_hi_fast_trip |=> r_r.lat_oc[`HSE_FTR_HI_BIT];
   endproperty
   a_hi_ftr_set: assert property (p_hi_ftr_set) else $error("hi fast trip flag not set"); // see (R02)

   property p_flag_hold;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      r_r.lat_oc[`HSE_FTR_LO_BIT] && !clr_oc |=> r_r.lat_oc[`HSE_FTR_LO_BIT];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("latched flag lost without read"); // see (R05)

   property p_turn_on_flag;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      s_hi_turn_on |-> r_r.lat_oc[`HSE_OC_HI_BIT] && r_r.lat_pg[`HSE_PG_HI_BIT];
   endproperty
   a_turn_on_flag: assert property (p_turn_on_flag) else $error("turn-on did not set flags"); // see (R06)

   property p_reset_off;
      @(posedge i_clk_sys)
      !i_resetn |=> !o_hi_rail_on && !o_lo_rail_on && r_r.lat_oc == 8'h00;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("rail on or flag set after reset"); // see (R12) (R13)

   property p_enable_and;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && !(i_lo_rail_enable_pin && r_r.ctrl[`HSE_CTRL_LO_EN_BIT]) |=> !o_lo_rail_on;
   endproperty
   a_enable_and: assert property (p_enable_and) else $error("lo rail on without pin and bit"); // see (R14) (R15)

   property p_bleed;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && !o_lo_rail_on && r_r.ctrl[`HSE_CTRL_LO_BLEED_BIT] && !i_lo_rail_output_below_bleed |=> !o_lo_rail_on;
   endproperty
   a_bleed: assert property (p_bleed) else $error("lo rail turned on before bleed-down"); // see (R16)

   property p_xconn;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      s_xtrip |=> !o_hi_rail_on && r_r.xconn;
   endproperty
   a_xconn: assert property (p_xconn) else $error("cross-connect did not stop hi rail"); // see (R17) (R20)

   property p_xconn_hold;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      r_r.xconn && r_r.ctrl[`HSE_CTRL_HI_EN_BIT] |-> !o_hi_rail_on;
   endproperty
   a_xconn_hold: assert property (p_xconn_hold) else $error("hi rail restarted without enable cycle"); // see (R20)

   property p_timeout;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      i_ce && i_lo_timer_expired |=> r_r.lat_pg[`HSE_FLT_LO_BIT];
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout flag not latched"); // see (R19)

   property p_clear;
      @(posedge i_clk_sys) disable iff (!i_resetn)
      clr_oc && set_oc == 8'h00 |=> r_r.lat_oc == 8'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("read did not clear latched flags"); // see (R21)

endmodule : hse_top
